// ===== tx_host_defs.svh
// offsets, fields, resets and sizes of the tx host
// assumes nothing; guarded against double inclusion
`ifndef TX_HOST_DEFS_SVH
`define TX_HOST_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_LANES 8'h04
`define OFF_DATA 8'h08
`define OFF_CMD 8'h0c
`define OFF_STATUS 8'h10
`define OFF_SENT 8'h14
`define OFF_ACKED 8'h18
`define OFF_SEGINFO 8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_CUT 0
`define CTRL_PAUSE 1
`define CTRL_PUSH 2
`define LANES_PUSH 4
`define CMD_SEND 0
`define CMD_FLUSH 1
`define ST_STREAMING 0
`define ST_BUSY 1
`define ST_OPEN 2
`define ST_DONE 3
`define ST_ERR 4
`define ST_ENGINE_LSB 8
`define ST_CAUSE_LSB 16

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define CTRL_RESET 3'h0
`define LANES_RESET 5'h0f
`define PKT_DEPTH 10'h200
`define PKT_ENTRY_W 37

`endif

// ===== tx_host_pkg.sv
// types and helpers of the tx host
// assumes tx_host_defs.svh supplies the numeric constants
package tx_host_pkg;

  // ----------------------------------------------------------------
  // streaming sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {st_idle, st_stream, st_drain} stream_state_type;

  // all state of the main controller
  typedef struct packed {
    stream_state_type state;
    logic cut;
    logic [9:0] count;
    logic [9:0] rd_ptr;
    logic [31:0] word;
    logic valid;
    logic [3:0] lanes;
    logic push;
    logic last;
    logic [15:0] seg_len;
    logic [15:0] seg_sum;
    logic [31:0] rdata;
    logic [2:0] ctrl;
    logic [4:0] lane_cfg;
    logic err;
    logic [4:0] cause;
    logic done;
  } main_state_type;

  // state of the checksum folder
  typedef struct packed {
    logic [15:0] sum;
    logic [15:0] bytes;
  } fold_state_type;

  // state of the acknowledge tally
  typedef struct packed {
    logic [31:0] sent;
    logic [31:0] acked;
  } tally_state_type;

  // number of valid low bytes for a lane pattern
  function automatic logic [2:0] lane_bytes(input logic [3:0] lanes);
    case (lanes)
      4'h1: lane_bytes = 3'h1;
      4'h3: lane_bytes = 3'h2;
      4'h7: lane_bytes = 3'h3;
      4'hf: lane_bytes = 3'h4;
      default: lane_bytes = 3'h0;
    endcase
  endfunction

  // zero every byte outside the enabled lanes
  function automatic logic [31:0] lane_mask(input logic [31:0] data, input logic [3:0] lanes);
    lane_mask = data & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

endpackage

// ===== payload_sum_fold.sv
// running 16-bit end-around-carry sum of payload halfwords, plus byte count
// assumes words arrive masked to their lanes
`timescale 1ns/1ps

module payload_sum_fold (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic clear, // restart the sum and count
  input wire logic add, // add one word this cycle
  input wire logic [31:0] word, // masked payload word
  input wire logic [3:0] lanes, // byte-lane enables of the word
  output logic [15:0] sum, // folded halfword sum
  output logic [15:0] bytes // byte total so far
);

  tx_host_pkg::fold_state_type s_q, s_d;
  logic [17:0] raw;
  logic [16:0] once;

  // ----------------------------------------------------------------
  // fold carries back into the low bits
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    raw = {2'h0, s_q.sum} + {2'h0, word[31:16]} + {2'h0, word[15:0]};
    once = {1'b0, raw[15:0]} + {15'h0, raw[17:16]};
    if (clear) begin
      s_d = '0;
    end else if (add) begin
      s_d.sum = once[15:0] + {15'h0, once[16]};
      s_d.bytes = s_q.bytes + {13'h0, tx_host_pkg::lane_bytes(lanes)};
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sum = s_q.sum;
  assign bytes = s_q.bytes;

endmodule

// ===== ack_tally.sv
// totals of bytes sent and bytes acknowledged
// assumes one-cycle acknowledge pulses on clk
`timescale 1ns/1ps

module ack_tally (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic clear, // zero both totals
  input wire logic sent_add, // one word transferred this cycle
  input wire logic [2:0] sent_bytes, // bytes in that word
  input wire logic ack_valid, // acknowledged count is valid
  input wire logic [15:0] ack_count, // newly acknowledged bytes
  output logic [31:0] sent_total, // bytes handed over
  output logic [31:0] acked_total, // bytes acknowledged
  output logic all_acked // totals agree
);

  tx_host_pkg::tally_state_type s_q, s_d;

  // ----------------------------------------------------------------
  // accumulate both totals; events in a clearing cycle are kept
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d = '0;
    end
    if (sent_add) begin
      s_d.sent = s_d.sent + {29'h0, sent_bytes};
    end
    if (ack_valid) begin
      s_d.acked = s_d.acked + {16'h0, ack_count};
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sent_total = s_q.sent;
  assign acked_total = s_q.acked;
  assign all_acked = (s_q.sent == s_q.acked);

endmodule

// ===== tx_offload_host.sv
// host streaming payload into a tcp offload engine
// assumes the engine runs on clk; software uses a plain port
//
// Summary of operation
// - simple mode: lanes and push travel with every word; moves on valid and accept
// - simple mode: host may drop valid before the last word to pause
// - after the last word is taken, the next packet waits until all bytes are acknowledged and busy is clear
// - simple mode: while accept is low, host holds every word signal steady
// - simple mode: lanes 0001b to 1111b allowed on any word
// - cut-through: length, checksum, push shown with first word, held until taken
// - cut-through: valid and accept stay high from first to last word
// - cut-through: lanes are 1111b on all but the final word; the host sends the lanes stored with each word, unchecked
// - cut-through: bytes delivered equal the length given with the first word
// - cut-through: a waiting new packet holds all its signals until accept
// - cut-through: final word enables 1-4 low bytes, upper bytes zero
// - cut-through checksum sums 16-bit halfwords, folding carries back in
`timescale 1ns/1ps
`include "tx_host_defs.svh"

module tx_offload_host #(
  parameter logic [3:0] code_connected = 4'h1, // arbitrary engine state code
  parameter logic [3:0] code_remote_reset = 4'h2, // arbitrary engine state code
  parameter logic [3:0] code_error = 4'h3 // arbitrary engine state code
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic tx_word_accept, // engine takes the word
  input wire logic [15:0] acked_byte_count, // newly acknowledged bytes
  input wire logic acked_count_valid, // acknowledged count pulse
  input wire logic command_busy_flag, // engine blocks commands
  input wire logic link_open_flag, // connection established
  input wire logic [3:0] engine_state, // engine state code
  input wire logic engine_interrupt, // engine interrupt
  input wire logic [4:0] interrupt_cause, // transmit error cause bits
  output logic [31:0] tx_payload_word, // payload word
  output logic tx_word_valid, // word is valid
  output logic [3:0] tx_byte_lanes, // byte-lane enables
  output logic tx_push_flag, // push flag
  output logic tx_last_word, // last word of packet
  output logic [15:0] tx_segment_length, // cut-through segment length
  output logic [15:0] tx_payload_sum // cut-through payload checksum
);

  // ----------------------------------------------------------------
  // packet store and state
  // ----------------------------------------------------------------
  logic [`PKT_ENTRY_W-1:0] pkt_mem [0:511]; // push, lanes, masked data
  tx_host_pkg::main_state_type s_q, s_d;

  logic wr_ctrl, wr_lanes, wr_data, wr_cmd, wr_status, wr_sent;
  logic send_req, flush_req, can_append;
  logic xfer, abort, pause_now;
  logic [31:0] in_word;
  logic [`PKT_ENTRY_W-1:0] next_entry, first_entry;
  logic [15:0] fold_sum, fold_bytes;
  logic [31:0] sent_total, acked_total;
  logic all_acked;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  assign wr_ctrl = wr && (addr == `OFF_CTRL);
  assign wr_lanes = wr && (addr == `OFF_LANES);
  assign wr_data = wr && (addr == `OFF_DATA);
  assign wr_cmd = wr && (addr == `OFF_CMD);
  assign wr_status = wr && (addr == `OFF_STATUS);
  assign wr_sent = wr && (addr == `OFF_SENT);
  assign send_req = wr_cmd && wdata[`CMD_SEND];
  assign flush_req = wr_cmd && wdata[`CMD_FLUSH] && (s_q.state == tx_host_pkg::st_idle);
  assign can_append = wr_data && (s_q.state == tx_host_pkg::st_idle) && (s_q.count != `PKT_DEPTH);

  // unused upper bytes are stored as zero
  assign in_word = tx_host_pkg::lane_mask(wdata, s_q.lane_cfg[3:0]);

  // ----------------------------------------------------------------
  // packet store write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && can_append) begin
      pkt_mem[s_q.count[8:0]] <= {s_q.lane_cfg[`LANES_PUSH], s_q.lane_cfg[3:0], in_word};
    end
  end

  assign next_entry = pkt_mem[s_q.rd_ptr[8:0]];
  assign first_entry = pkt_mem[9'h000];

  // ----------------------------------------------------------------
  // checksum and byte count of the loaded packet
  // ----------------------------------------------------------------
  payload_sum_fold u_fold (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .clear(flush_req),
    .add(can_append),
    .word(in_word),
    .lanes(s_q.lane_cfg[3:0]),
    .sum(fold_sum),
    .bytes(fold_bytes)
  );

  // ----------------------------------------------------------------
  // sent and acknowledged totals
  // ----------------------------------------------------------------
  ack_tally u_tally (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .clear(wr_sent),
    .sent_add(xfer),
    .sent_bytes(tx_host_pkg::lane_bytes(s_q.lanes)),
    .ack_valid(acked_count_valid),
    .ack_count(acked_byte_count),
    .sent_total(sent_total),
    .acked_total(acked_total),
    .all_acked(all_acked)
  );

  // ----------------------------------------------------------------
  // stream conditions
  // ----------------------------------------------------------------
  // a word moves on valid and accept
  assign xfer = s_q.valid && tx_word_accept;
  // peer reset, error or lost link ends the stream
  assign abort = !link_open_flag || (engine_state == code_remote_reset)
    || (engine_state == code_error) || engine_interrupt;
  // pause only in simple mode
  assign pause_now = !s_q.cut && s_q.ctrl[`CTRL_PAUSE];

  // status word read by software
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_STREAMING] = (s_q.state != tx_host_pkg::st_idle);
    status_word[`ST_BUSY] = command_busy_flag;
    status_word[`ST_OPEN] = link_open_flag;
    status_word[`ST_DONE] = s_q.done;
    status_word[`ST_ERR] = s_q.err;
    status_word[`ST_ENGINE_LSB +: 4] = engine_state;
    status_word[`ST_CAUSE_LSB +: 5] = s_q.cause;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // configuration registers
    if (wr_ctrl) begin
      s_d.ctrl = wdata[2:0];
    end
    if (wr_lanes) begin
      s_d.lane_cfg = wdata[4:0];
    end
    if (can_append) begin
      s_d.count = s_q.count + 10'h001;
    end
    if (flush_req) begin
      s_d.count = 10'h000;
    end

    // sticky error; a new event wins over the clear
    if (wr_status && wdata[`ST_ERR]) begin
      s_d.err = 1'b0;
      s_d.cause = 5'h00;
    end
    if (wr_cmd && wdata[`CMD_SEND]) begin
      s_d.done = 1'b0;
    end
    if (engine_interrupt) begin
      s_d.err = 1'b1;
      s_d.cause = s_q.cause | interrupt_cause;
    end

    // read data stands one cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `OFF_CTRL: s_d.rdata = {29'h0, s_q.ctrl};
        `OFF_LANES: s_d.rdata = {27'h0, s_q.lane_cfg};
        `OFF_DATA: s_d.rdata = {22'h0, s_q.count};
        `OFF_STATUS: s_d.rdata = status_word;
        `OFF_SENT: s_d.rdata = sent_total;
        `OFF_ACKED: s_d.rdata = acked_total;
        `OFF_SEGINFO: s_d.rdata = {fold_sum, fold_bytes};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // streaming sequencer
    case (s_q.state)
      tx_host_pkg::st_idle: begin
        // send only in session with busy clear
        if (send_req && (s_q.count != 10'h000) && !abort && !command_busy_flag
            && (engine_state == code_connected)) begin
          s_d.state = tx_host_pkg::st_stream;
          s_d.cut = s_q.ctrl[`CTRL_CUT];
          s_d.word = first_entry[31:0];
          s_d.lanes = first_entry[35:32];
          s_d.last = (s_q.count == 10'h001);
          s_d.rd_ptr = 10'h001;
          // length, sum and push go with the first word
          s_d.seg_len = fold_bytes;
          s_d.seg_sum = fold_sum;
          s_d.push = s_q.ctrl[`CTRL_CUT] ? s_q.ctrl[`CTRL_PUSH] : first_entry[36];
          s_d.valid = s_q.ctrl[`CTRL_CUT] || !s_q.ctrl[`CTRL_PAUSE];
        end
      end

      tx_host_pkg::st_stream: begin
        if (abort) begin
          // peer reset, error or lost link: stop offering
          s_d.valid = 1'b0;
          s_d.last = 1'b0;
          s_d.err = 1'b1;
          s_d.state = tx_host_pkg::st_idle;
        end else if (xfer && s_q.last) begin
          // packet complete; engine post-processes
          s_d.valid = 1'b0;
          s_d.last = 1'b0;
          s_d.state = tx_host_pkg::st_drain;
        end else if (xfer) begin
          // advance; cut-through keeps valid high every cycle
          s_d.word = next_entry[31:0];
          s_d.lanes = next_entry[35:32];
          if (!s_q.cut) begin
            s_d.push = next_entry[36];
          end
          s_d.last = ((s_q.rd_ptr + 10'h001) == s_q.count);
          s_d.rd_ptr = s_q.rd_ptr + 10'h001;
          s_d.valid = !pause_now;
        end else if (!s_q.valid && !pause_now) begin
          // resume a paused simple-mode packet
          s_d.valid = 1'b1;
        end
        // otherwise everything holds while accept is low
      end

      tx_host_pkg::st_drain: begin
        // wait for all acks and busy clear
        if (abort && !link_open_flag) begin
          s_d.state = tx_host_pkg::st_idle;
        end else if (all_acked && !command_busy_flag) begin
          s_d.done = 1'b1;
          s_d.state = tx_host_pkg::st_idle;
        end
      end

      default: begin
        s_d.state = tx_host_pkg::st_idle;
        s_d.valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.state <= tx_host_pkg::st_idle;
      s_q.ctrl <= `CTRL_RESET;
      s_q.lane_cfg <= `LANES_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign rdata = s_q.rdata;
  assign tx_payload_word = s_q.word;
  assign tx_word_valid = s_q.valid;
  assign tx_byte_lanes = s_q.lanes;
  assign tx_push_flag = s_q.push;
  assign tx_last_word = s_q.last;
  assign tx_segment_length = s_q.seg_len;
  assign tx_payload_sum = s_q.seg_sum;

endmodule

// ===== tx_host_sva.sv
// checker on the tx host's ports
// assumes a bind to tx_offload_host
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module tx_host_sva #(
  parameter logic [3:0] code_connected = 4'h1, // arbitrary engine state code
  parameter logic [3:0] code_remote_reset = 4'h2 // arbitrary engine state code
) (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic tx_word_accept, // engine takes the word
  input wire logic link_open_flag, // connection established
  input wire logic [3:0] engine_state, // engine state code
  input wire logic engine_interrupt, // engine interrupt
  input wire logic [31:0] tx_payload_word, // payload word
  input wire logic tx_word_valid, // word valid
  input wire logic [3:0] tx_byte_lanes, // byte-lane enables
  input wire logic tx_push_flag, // push flag
  input wire logic tx_last_word, // last word
  input wire logic [15:0] tx_segment_length, // segment length
  input wire logic [15:0] tx_payload_sum // payload checksum
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // word held off, no abort pending
  sequence stalled;
    ce && tx_word_valid && !tx_word_accept && link_open_flag && !engine_interrupt
      && engine_state == code_connected;
  endsequence
  // last word taken
  sequence last_taken;
    ce && tx_word_valid && tx_word_accept && tx_last_word;
  endsequence

  hold_stall_a: assert property (stalled |=> tx_word_valid &&
    $stable(tx_payload_word) && $stable(tx_byte_lanes) && $stable(tx_push_flag)
    && $stable(tx_last_word)) else $error("word changed while held off");
  seg_steady_a: assert property (ce && tx_word_valid |=> !tx_word_valid ||
    ($stable(tx_segment_length) && $stable(tx_payload_sum)))
    else $error("length or sum moved");
  lanes_legal_a: assert property (tx_word_valid |->
    tx_byte_lanes inside {4'h1, 4'h3, 4'h7, 4'hf}) else $error("illegal lane pattern");
  upper_zero_a: assert property (tx_word_valid |-> (tx_payload_word &
    ~{{8{tx_byte_lanes[3]}}, {8{tx_byte_lanes[2]}}, {8{tx_byte_lanes[1]}},
    {8{tx_byte_lanes[0]}}}) == 32'h0) else $error("unused bytes not zero");
  remote_drop_a: assert property (ce && engine_state == code_remote_reset |=>
    !tx_word_valid) else $error("word in remote reset");
  closed_drop_a: assert property (ce && !link_open_flag |=> !tx_word_valid)
    else $error("word with no link");
  one_packet_a: assert property (last_taken |=> !tx_word_valid)
    else $error("word after last word");
  rdata_idle_a: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("stray read data");
  last_cov: cover property (last_taken);
endmodule

// ===== engine_model.sv
// model of the engine's user transmit port
// assumes bench inputs change by non-blocking assignment
`timescale 1ns/1ps

// ----------------------------------------------------------------
// engine model
// ----------------------------------------------------------------
module engine_model #(
  parameter logic [3:0] code_idle = 4'h0, // arbitrary engine state code
  parameter logic [3:0] code_connected = 4'h1, // arbitrary engine state code
  parameter logic [3:0] code_remote_reset = 4'h2 // arbitrary engine state code
) (
  input wire logic clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic tx_word_valid, // word valid
  input wire logic [3:0] tx_byte_lanes, // byte-lane enables
  input wire logic tx_last_word, // last word
  input wire logic cut, // bench: cut-through
  input wire logic stall, // bench: hold accept low
  input wire logic open_req, // bench: open the session
  input wire logic peer_rst, // bench: peer reset
  output logic tx_word_accept, // engine takes the word
  output logic [15:0] acked_byte_count, // newly acknowledged bytes
  output logic acked_count_valid, // acknowledged count pulse
  output logic command_busy_flag, // busy
  output logic link_open_flag, // connection open
  output logic [3:0] engine_state, // state code
  output logic engine_interrupt, // interrupt, never raised here
  output logic [4:0] interrupt_cause // cause bits
);
  logic rr_q;
  logic in_pkt;
  logic [3:0] fcnt, acnt, bcnt, rcnt, post;
  logic [15:0] pend;

  // accept in session only, not after the first cycle of remote reset or in post-processing
  assign tx_word_accept = link_open_flag & !rr_q & !stall & (post == 4'h0);
  assign engine_interrupt = 1'b0;
  assign interrupt_cause = 5'h0;

  // session, busy and acknowledge sequencing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {rr_q, in_pkt, acked_count_valid, command_busy_flag, link_open_flag} <= 5'h0;
      {fcnt, acnt, bcnt, rcnt, post} <= 20'h0;
      pend <= 16'h0;
      acked_byte_count <= 16'h0;
      engine_state <= code_idle;
    end else begin
      rr_q <= (engine_state == code_remote_reset);
      acked_count_valid <= 1'b0;
      acked_byte_count <= ~acked_byte_count; // junk between pulses
      if (post != 4'h0) post <= post - 4'h1;
      if (fcnt != 4'h0) fcnt <= fcnt - 4'h1;
      if (fcnt == 4'h1) command_busy_flag <= 1'b1;
      if (bcnt != 4'h0) bcnt <= bcnt - 4'h1;
      if (bcnt == 4'h1) command_busy_flag <= 1'b0;
      if (acnt != 4'h0) acnt <= acnt - 4'h1;
      if (tx_word_valid && tx_word_accept) begin
        pend <= pend + 16'($countones(tx_byte_lanes));
        in_pkt <= !tx_last_word;
        if (!in_pkt) fcnt <= 4'h6;
        if (tx_last_word) acnt <= 4'ha;
        if (tx_last_word && cut) post <= 4'h2;
      end
      // two acks summing to the bytes taken
      if (acnt == 4'h4) begin
        acked_count_valid <= 1'b1;
        acked_byte_count <= 16'h2;
        pend <= pend - 16'h2;
      end
      if (acnt == 4'h1) begin
        acked_count_valid <= 1'b1;
        acked_byte_count <= pend;
        pend <= 16'h0;
        bcnt <= 4'h3;
      end
      if (engine_state == code_idle && open_req) begin
        engine_state <= code_connected;
        link_open_flag <= 1'b1;
      end
      if (engine_state == code_connected && peer_rst) begin
        engine_state <= code_remote_reset;
        command_busy_flag <= 1'b1;
        rcnt <= 4'h5;
      end
      if (rcnt != 4'h0) rcnt <= rcnt - 4'h1;
      if (rcnt == 4'h1) begin
        engine_state <= code_idle;
        link_open_flag <= 1'b0;
        command_busy_flag <= 1'b0;
      end
    end
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the tx host
// assumes the engine model and checker are compiled alongside
`timescale 1ns/1ps
`include "tx_host_defs.svh"

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic cut = 1'b0, stall = 1'b0, open_req = 1'b0, peer_rst = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, v, tx_payload_word;
  logic tx_word_accept, acked_count_valid, command_busy_flag, link_open_flag, engine_interrupt;
  logic [15:0] acked_byte_count, tx_segment_length, tx_payload_sum;
  logic [3:0] engine_state, tx_byte_lanes;
  logic [4:0] interrupt_cause;
  logic tx_word_valid, tx_push_flag, tx_last_word;
  int errors = 0, cmp_count = 0, cyc = 0;

  always #5 clk = ~clk;

  engine_model eng (.clk, .nrst, .tx_word_valid, .tx_byte_lanes, .tx_last_word, .cut,
    .stall, .open_req, .peer_rst, .tx_word_accept, .acked_byte_count, .acked_count_valid,
    .command_busy_flag, .link_open_flag, .engine_state, .engine_interrupt, .interrupt_cause);
  tx_offload_host uut (.clk, .nrst, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata,
    .tx_word_accept, .acked_byte_count, .acked_count_valid, .command_busy_flag,
    .link_open_flag, .engine_state, .engine_interrupt, .interrupt_cause, .tx_payload_word,
    .tx_word_valid, .tx_byte_lanes, .tx_push_flag, .tx_last_word, .tx_segment_length,
    .tx_payload_sum);

  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read; data taken the cycle after
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    rd_reg(a, t);
    chk(t, exp);
  endtask
  // send with the first word held off, check it, then poll done
  task automatic run_send(input logic [31:0] w, input logic [31:0] s);
    int n;
    stall <= 1'b1;
    wr_reg(`OFF_CMD, 32'h1);
    repeat (3) @(posedge clk);
    chk(tx_payload_word, w);
    chk({tx_segment_length, tx_payload_sum}, s);
    stall <= 1'b0;
    n = 0;
    v = 32'h0;
    while (v[`ST_DONE] !== 1'b1 && n < 200) begin
      rd_reg(`OFF_STATUS, v);
      n++;
    end
    chk({31'h0, v[`ST_DONE]}, 32'h1);
  endtask
  task test_done;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`OFF_CTRL, 32'h0);
    rd_chk(`OFF_LANES, 32'h0f);
    rd_chk(8'h20, 32'h0);
    // send refused with no session
    wr_reg(`OFF_DATA, 32'h12345678);
    wr_reg(`OFF_CMD, 32'h1);
    rd_chk(`OFF_STATUS, 32'h0);
    wr_reg(`OFF_CMD, 32'h2);
    open_req <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`OFF_STATUS, 32'h104);
    // simple mode, lanes 1,3,7,f, push on one word
    for (int i = 0; i < 4; i++) begin
      wr_reg(`OFF_LANES, ((32'h1 << (i + 1)) - 32'h1) | (i == 2 ? 32'h10 : 32'h0));
      wr_reg(`OFF_DATA, 32'hffffff00 | i);
    end
    run_send(32'h0, 32'h000afe07);
    rd_chk(`OFF_SENT, 32'd10);
    rd_chk(`OFF_ACKED, 32'd10);
    // cut-through, 14 bytes sent twice
    wr_reg(`OFF_SENT, 32'h0);
    wr_reg(`OFF_CTRL, 32'h5);
    cut <= 1'b1;
    wr_reg(`OFF_CMD, 32'h2);
    wr_reg(`OFF_LANES, 32'h0f);
    for (int i = 1; i < 4; i++) wr_reg(`OFF_DATA, 32'h11111111 * i);
    wr_reg(`OFF_LANES, 32'h03);
    wr_reg(`OFF_DATA, 32'hffffdddd);
    rd_chk(`OFF_SEGINFO, 32'haaaa000e);
    run_send(32'h11111111, 32'h000eaaaa);
    run_send(32'h11111111, 32'h000eaaaa);
    rd_chk(`OFF_SENT, 32'd28);
    rd_chk(`OFF_ACKED, 32'd28);
    // peer reset while a word is held off
    wr_reg(`OFF_CTRL, 32'h0);
    cut <= 1'b0;
    stall <= 1'b1;
    wr_reg(`OFF_CMD, 32'h1);
    peer_rst <= 1'b1;
    open_req <= 1'b0;
    @(posedge clk);
    peer_rst <= 1'b0;
    rd_reg(`OFF_STATUS, v);
    chk({28'h0, v[11:8]}, 32'h2);
    chk({31'h0, v[`ST_BUSY]}, 32'h1);
    repeat (8) @(posedge clk);
    stall <= 1'b0;
    rd_chk(`OFF_STATUS, 32'h10);
    wr_reg(`OFF_STATUS, 32'h10);
    rd_chk(`OFF_STATUS, 32'h0);
    test_done;
  end
endmodule

bind tx_offload_host tx_host_sva #(.code_connected(code_connected),
  .code_remote_reset(code_remote_reset)) sva_i (.clk, .nrst, .ce, .rd, .rdata,
  .tx_word_accept, .link_open_flag, .engine_state, .engine_interrupt, .tx_payload_word,
  .tx_word_valid, .tx_byte_lanes, .tx_push_flag, .tx_last_word, .tx_segment_length,
  .tx_payload_sum);
